//--- irc_bfm.sv
// irc_bfm: i2c master model, 125 ns bits; scl stands high between frames
`timescale 1ns/1ps
module irc_bfm (output logic scl = 1'b1, output logic sda_m = 1'b1, input wire logic sda);
  task automatic cond(input logic go); // start if go, else stop
    #31.25 sda_m = go;
    #31.25 scl = 1;
    #62.5 sda_m = !go;
    #62.5 scl = !go;
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] q); // bit 0 is ack
    for (int i = 8; i >= 0; i--) begin
      #31.25 sda_m = d[i];
      #31.25 scl = 1;
      #31.25 q[i] = sda;
      #31.25 scl = 0;
    end
  endtask
endmodule // irc_bfm

//--- irc_chk.sv
// irc_chk: irc_slave port assertions; sda_oe_n low drives sda_o onto sda
`timescale 1ns/1ps
module irc_chk (input wire logic mclk, rst_n, scl_i, sda_oe_n, busy,
  input wire irc_pkg::irc_req_s reg_req);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_addr_low: assert property (reg_req.valid |-> !reg_req.addr[1:0]) else $error("adr");
  a_req_busy: assert property (reg_req.valid |-> busy) else $error("busy");
  a_req_pulse: assert property (reg_req.valid |=> !reg_req.valid) else $error("pulse");
  a_idle_quiet: assert property (!busy |-> sda_oe_n) else $error("idle");
  a_scl_low: assert property ($changed(sda_oe_n) |-> !scl_i) else $error("scl");
  a_busy_rise: assert property ($rose(busy) |-> sda_oe_n) else $error("rise");
  a_drv_min: assert property ($fell(sda_oe_n) |-> (!sda_oe_n)[*4]) else $error("min");
  a_drv_max: assert property ($fell(sda_oe_n) |-> ##[1:300] sda_oe_n) else $error("max");
  cover property (reg_req.valid && reg_req.write);
  cover property (reg_req.valid && !reg_req.write);
  cover property ($fell(sda_oe_n));
endmodule // irc_chk
bind irc_slave irc_chk irc_chk_i (.mclk(mclk), .rst_n(rst_n), .scl_i(scl_i),
  .sda_oe_n(sda_oe_n), .busy(busy), .reg_req(reg_req));

//--- irc_pkg.sv
// irc_pkg: constants and carrier types for the i2c register access slave
// assumes one 100 MHz core clock; scl/sda are sampled asynchronously
// ============================================================
// Notes on behaviour
// [RQ1] a register read is a command transfer (address+write, four command bytes) then a data transfer (address+read, four bytes).
// [RQ2] an address byte with bit 0 set starts a read transfer and the device returns data in it.
// [RQ3] a complete read command fetches the selected port's register into a 32-bit holding buffer.
// [RQ4] read data leaves the holding buffer bits 31:24 first and bits 7:0 last.
// [RQ5] reading past the fourth byte wraps back to the most significant buffer byte.
// [RQ6] a repeated start between command and read transfer is handled like a stop and a new start.
// [RQ7] command byte 0 bits 2:0 hold the operation, 100b is read, bits 7:3 are reserved.
// [RQ8] port select high bit is command byte 1 bit 0, low bit is command byte 2 bit 7.
// [RQ9] command byte 2 bits 5:2 are byte enables for register bytes 0 to 3, one allows a change.
// [RQ10] address bits 11:10 are command byte 2 bits 1:0, bits 9:2 are command byte 3, bits 1:0 are zero.
// [RQ11] write data arrives most significant byte first, first byte to bits 31:24.
// [RQ12] operation 011b is a register write using the same port, enable and address fields.
// [RQ13] the device acks each address, command and write byte; the master acks read bytes and stops.
package irc_pkg;
  localparam logic [2:0] IRC_OP_WRITE  = 3'h3;
  localparam logic [2:0] IRC_OP_READ   = 3'h4;
  localparam logic [6:0] IRC_SADDR_RST = 7'h38;  // arbitrary default slave address
  localparam int         IRC_CMD_BYTES = 4;
  localparam int         IRC_DAT_BYTES = 4;
  localparam int         IRC_RW_BIT    = 0;
  localparam int         IRC_PSEL_HI   = 0;
  localparam int         IRC_PSEL_LO   = 7;
  localparam int         IRC_BE_MSB    = 5;
  localparam int         IRC_BE_LSB    = 2;
  localparam logic       IRC_LINE_IDLE = 1'b1;  // released bus level, also the synchroniser reset
  localparam logic [3:0] IRC_BYTE_BITS = 4'h8;  // clock rises in one byte before its ack bit
  localparam logic [3:0] IRC_LAST_CMD  = 4'h3;  // index of the last command byte
  localparam logic [3:0] IRC_LAST_DAT  = 4'h7;  // index of the last write data byte
  localparam logic [3:0] IRC_BYTE_SAT  = 4'h8;  // byte counter stops here

  typedef enum logic [2:0] {
    IRC_IDLE, IRC_ADDR, IRC_ACK, IRC_RX, IRC_TX, IRC_MACK, IRC_SKIP
  } irc_state_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [1:0] port;
    logic [3:0] be;
    logic [11:0] addr;
    logic [31:0] data;
  } irc_req_s;
endpackage

//--- irc_slave.sv
// irc_slave: i2c slave giving an external master access to 32-bit config registers
// assumes the register side answers a read one mclk after reg_req with reg_rdata valid
`timescale 1ns/1ps
module irc_slave (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [6:0]       slave_addr,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_n,
  output irc_pkg::irc_req_s     reg_req,
  input  wire logic [31:0]      reg_rdata,
  output logic                  busy
);
  import irc_pkg::*;

  // ============================================================
  // state
  // every flop sits in one record so the clock enable treats all of it alike; reset zeroes all but the line samples, which it sets high
  typedef struct packed {
    logic [1:0]  scl_s;   // two-flop synchroniser for the clock pin
    logic [1:0]  sda_s;   // two-flop synchroniser for the data pin
    logic        scl_q;   // previous synchronised clock, for edges
    logic        sda_q;   // previous synchronised data, for start and stop
    irc_state_e  st;
    logic [3:0]  bitc;    // clock rises seen in the current byte
    logic [7:0]  sh;      // receive and transmit shifter
    logic        rd;      // current transfer returns data
    logic [3:0]  bytec;   // bytes taken since the address, saturates
    logic [7:0]  cmd0;
    logic [7:0]  cmd1;
    logic [7:0]  cmd2;
    logic [7:0]  cmd3;
    logic [31:0] wdat;
    logic [31:0] hold;    // read holding buffer
    logic [1:0]  rptr;    // next holding buffer byte, 0 is bits 31:24
    logic        mack;    // master acked the last read byte
    logic        fetch;   // capture reg_rdata on this edge
    logic        drv;
    logic        dout;
    logic        bsy;
    irc_req_s    req;
  } irc_st_s;

  irc_st_s s_r;
  irc_st_s s_nxt;

  // ============================================================
  // pin sampling and bus events
  // only the second synchroniser stage is read; the third stage just finds edges
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       byte_end;
  logic       rd_cmd;
  logic       wr_cmd;
  logic [7:0] tx_byte;

  assign scl      = s_r.scl_s[1];
  assign sda      = s_r.sda_s[1];
  assign scl_rise = scl & ~s_r.scl_q;
  assign scl_fall = ~scl & s_r.scl_q;
  assign start_c  = scl & s_r.scl_q & s_r.sda_q & ~sda;
  assign stop_c   = scl & s_r.scl_q & ~s_r.sda_q & sda;
  assign byte_end = scl_fall & (s_r.bitc == IRC_BYTE_BITS);

  // ============================================================
  // holding buffer byte chosen by the read pointer, most significant first
  always_comb begin
    case (s_r.rptr)
      2'h0:    tx_byte = s_r.hold[31:24];  // [RQ4]
      2'h1:    tx_byte = s_r.hold[23:16];
      2'h2:    tx_byte = s_r.hold[15:8];
      default: tx_byte = s_r.hold[7:0];
    endcase
  end

  // ============================================================
  // command decode
  // reserved bits of command byte 0 are ignored, only the low three pick the operation
  assign rd_cmd = (s_r.cmd0[2:0] == IRC_OP_READ);   // [RQ7]
  assign wr_cmd = (s_r.cmd0[2:0] == IRC_OP_WRITE);  // [RQ12]

  // ============================================================
  // next state
  always_comb begin
    s_nxt           = s_r;
    s_nxt.scl_s     = {s_r.scl_s[0], scl_i};
    s_nxt.sda_s     = {s_r.sda_s[0], sda_i};
    s_nxt.scl_q     = scl;
    s_nxt.sda_q     = sda;
    s_nxt.req.valid = 1'b0;
    // the register side answers a cycle after the request, so capture one cycle later
    s_nxt.fetch     = s_r.req.valid & ~s_r.req.write;
    if (s_r.fetch) begin
      s_nxt.hold = reg_rdata;  // [RQ3]
    end
    if (start_c) begin
      // repeated start restarts the address phase, same as after a stop [RQ6]
      s_nxt.st    = IRC_ADDR;
      s_nxt.bitc  = 4'h0;
      s_nxt.drv   = 1'b0;
      s_nxt.bytec = 4'h0;
      s_nxt.rptr  = 2'h0;
    end else if (stop_c) begin
      s_nxt.st  = IRC_IDLE;
      s_nxt.drv = 1'b0;
    end else begin
      case (s_r.st)
        IRC_IDLE: begin
          s_nxt.drv = 1'b0;
        end
        IRC_ADDR: begin
          if (scl_rise) begin
            s_nxt.sh   = {s_r.sh[6:0], sda};
            s_nxt.bitc = s_r.bitc + 4'h1;
          end
          if (byte_end) begin
            s_nxt.bitc = 4'h0;
            if (s_r.sh[7:1] == slave_addr) begin
              s_nxt.rd   = s_r.sh[IRC_RW_BIT];  // [RQ2]
              s_nxt.drv  = 1'b1;                // [RQ13]
              s_nxt.dout = 1'b0;
              s_nxt.st   = IRC_ACK;
            end else begin
              // another slave's transfer: stay off the line until the next start or stop
              s_nxt.st = IRC_SKIP;
            end
          end
        end
        IRC_RX: begin
          if (scl_rise) begin
            s_nxt.sh   = {s_r.sh[6:0], sda};
            s_nxt.bitc = s_r.bitc + 4'h1;
          end
          if (byte_end) begin
            s_nxt.bitc = 4'h0;
            s_nxt.drv  = 1'b1;  // [RQ13]
            s_nxt.dout = 1'b0;
            s_nxt.st   = IRC_ACK;
            case (s_r.bytec)
              4'h0:    s_nxt.cmd0 = s_r.sh;                      // [RQ7]
              4'h1:    s_nxt.cmd1 = s_r.sh;                      // [RQ8]
              4'h2:    s_nxt.cmd2 = s_r.sh;                      // [RQ9]
              4'h3:    s_nxt.cmd3 = s_r.sh;                      // [RQ10]
              default: s_nxt.wdat = {s_r.wdat[23:0], s_r.sh};  // [RQ11]
            endcase
            if (s_r.bytec != IRC_BYTE_SAT) begin
              s_nxt.bytec = s_r.bytec + 4'h1;
            end
            // a read fetches once its last command byte lands, ready for the data transfer
            if (s_r.bytec == IRC_LAST_CMD && rd_cmd) begin
              s_nxt.req.valid = 1'b1;  // [RQ1] [RQ3]
            end
            if (s_r.bytec == IRC_LAST_DAT && wr_cmd) begin
              s_nxt.req.valid = 1'b1;  // [RQ12]
            end
          end
        end
        IRC_ACK: begin
          // the ack bit ends on the next fall; a read transfer goes straight to data
          if (scl_fall) begin
            s_nxt.bitc = 4'h0;
            if (s_r.rd) begin
              s_nxt.sh   = tx_byte;
              s_nxt.rptr = s_r.rptr + 2'h1;  // [RQ5]
              s_nxt.dout = tx_byte[7];       // [RQ4]
              s_nxt.st   = IRC_TX;
            end else begin
              s_nxt.drv = 1'b0;
              s_nxt.st  = IRC_RX;
            end
          end
        end
        IRC_TX: begin
          if (scl_rise) begin
            s_nxt.bitc = s_r.bitc + 4'h1;
          end
          if (byte_end) begin
            s_nxt.drv = 1'b0;  // hand the line to the master for its ack
            s_nxt.st  = IRC_MACK;
          end else if (scl_fall) begin
            s_nxt.sh   = {s_r.sh[6:0], 1'b0};
            s_nxt.dout = s_r.sh[6];
          end
        end
        IRC_MACK: begin
          if (scl_rise) begin
            s_nxt.mack = ~sda;  // [RQ13]
          end
          if (scl_fall) begin
            s_nxt.bitc = 4'h0;
            if (s_r.mack) begin
              s_nxt.drv  = 1'b1;
              s_nxt.sh   = tx_byte;
              s_nxt.rptr = s_r.rptr + 2'h1;  // wraps to bits 31:24 after four [RQ5]
              s_nxt.dout = tx_byte[7];       // [RQ4]
              s_nxt.st   = IRC_TX;
            end else begin
              // a missing ack ends the read; wait for the master's stop
              s_nxt.st = IRC_SKIP;
            end
          end
        end
        default: begin
          s_nxt.drv = 1'b0;
        end
      endcase
    end

    // request fields only change with a request, so the register side sees them steady
    if (s_nxt.req.valid) begin
      s_nxt.req.write = wr_cmd;
      s_nxt.req.port  = {s_nxt.cmd1[IRC_PSEL_HI], s_nxt.cmd2[IRC_PSEL_LO]};  // [RQ8]
      s_nxt.req.be    = s_nxt.cmd2[IRC_BE_MSB:IRC_BE_LSB];                    // [RQ9]
      s_nxt.req.addr  = {s_nxt.cmd2[1:0], s_nxt.cmd3, 2'b00};                 // [RQ10]
      s_nxt.req.data  = wr_cmd ? s_nxt.wdat : 32'h0000_0000;                  // [RQ11]
    end
    s_nxt.bsy = (s_nxt.st != IRC_IDLE);
  end

  // ============================================================
  // registers
  // a low clock enable freezes the synchronisers too, so bus edges while it is low are not seen
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r       <= '0;
      s_r.scl_s <= {2{IRC_LINE_IDLE}};
      s_r.sda_s <= {2{IRC_LINE_IDLE}};
      s_r.scl_q <= IRC_LINE_IDLE;
      s_r.sda_q <= IRC_LINE_IDLE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ============================================================
  // outputs
  assign sda_o    = s_r.dout;
  assign sda_oe_n = ~s_r.drv;
  assign reg_req  = s_r.req;
  assign busy     = s_r.bsy;
endmodule // irc_slave

//--- tb.sv
// tb: irc_slave against the master model and a register stub
`timescale 1ns/1ps
module tb;
  logic mclk = 0, rst_n = 0, ce = 1, scl, sda_m, sda_o, sda_oe_n, busy;
  logic [6:0] sa = irc_pkg::IRC_SADDR_RST;
  logic [31:0] rd = 32'h0;
  logic [8:0] q;
  irc_pkg::irc_req_s rq, last;
  int miscompares = 0, checks_done = 0;
  wire sda = sda_m & (sda_oe_n | sda_o); // pull-up
  irc_slave irc_slave_i (.mclk(mclk), .rst_n(rst_n), .ce(ce), .slave_addr(sa), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .reg_req(rq), .reg_rdata(rd), .busy(busy));
  irc_bfm irc_bfm_i (.scl(scl), .sda_m(sda_m), .sda(sda));
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) if (rq.valid) last <= rq;
  always @(posedge mclk) rd <= (rq.valid && !rq.write) ? 32'hA1B2C3D4 : ~rd; // stale toggles
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (!ok) begin
      miscompares++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic wb(input logic [7:0] d);
    irc_bfm_i.xfer({d, 1'b1}, q);
    chk(q[0] === 1'b0, "nak");
  endtask
  task automatic t_freeze();
    @(posedge mclk) #1 ce = 1'b0;
    irc_bfm_i.cond(1);
    chk(busy === 1'b0, "frozen start seen");
    @(posedge mclk) #1 ce = 1'b1;
    irc_bfm_i.cond(0);
    repeat (4) @(posedge mclk);
    chk(busy === 1'b0 && sda_oe_n === 1'b1, "idle after freeze");
    $display("freeze test done");
  endtask
  task automatic t_write();
    logic [7:0] b[9] = '{8'h70, 8'h03, 8'h01, 8'h14, 8'h2D, 8'h12, 8'h34, 8'h56, 8'h78};
    irc_bfm_i.cond(1);
    foreach (b[i]) wb(b[i]);
    irc_bfm_i.cond(0);
    repeat (20) @(posedge mclk);
    chk(last === {4'hE, 4'h5, 12'h0B4, 32'h12345678}, "wr");
    $display("write test done");
  endtask
  task automatic t_read();
    logic [7:0] b[6] = '{8'h70, 8'h04, 8'h00, 8'hBC, 8'h2D, 8'h71};
    logic [39:0] e = 40'hA1B2C3D4A1;
    foreach (b[i]) begin
      if (i % 5 == 0) irc_bfm_i.cond(1);
      wb(b[i]);
    end
    chk(last[51:44] === 8'h9F && last.addr === 12'h0B4, "rq");
    for (int i = 0; i < 5; i++) begin
      irc_bfm_i.xfer({8'hFF, i == 4}, q);
      chk(q[8:1] === e[39 - 8 * i -: 8], "rd");
    end
    irc_bfm_i.cond(0);
    $display("read test done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    #1 rst_n = 1;
    t_freeze();
    t_write();
    t_read();
    stop_test();
  end
  initial begin
    repeat (9000) @(posedge mclk);
    miscompares++;
    stop_test();
  end
endmodule // tb
